/* hw/gtos_core.sv */
`timescale 1ns/1ps
// Operation
// - Second pulse runs on from a free counter whatever the lock state.
// - Even-second pulse fires only when the second count is even.
// - Programmable pulse is one-shot at a set time or periodic, 1 s to 1 year.
// - One time-code frame of 100 bits goes out each second.
// - Frame holds BCD day, hour, minute, second and binary seconds of day.
// - Carrier output is a free 1 kHz square wave, not keyed by the frame bits.
// - Relay drive and alarm indicator switch together.
// - Relay drive is high to close, so an unpowered relay rests open.
// - Logic alarm line is low while the alarm is set.
// - Lock indicator lights only while locked to tracked satellite seconds.
// - Outputs are flagged unusable until the first lock after reset.
// - Holdover indicator lights whenever not locked after the first lock.
// - Host hold command enters manual holdover; a recover command leaves it.
// - Holdover from lost tracking ends by itself when tracking returns.
// - Holdover spec flag needs 24 h warm-up and 48 h of lock.
// - Alarm latches until the host clears it.
// - Power indicator shows power only and has no register.
// - Firmware upgrade is granted from the rear port only.
// - Each command port reaches holdover and alarm commands on its own.
module gtos_core
   import gtos_pkg::*;
#(
   parameter logic [15:0] CYC_PER_MS = CYC_PER_MS_DEF[15:0]
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tracking_i,
   input wire logic alarm_cond_i,
   input wire logic [1:0] hold_cmd_i,
   input wire logic [1:0] recover_cmd_i,
   input wire logic [1:0] alarm_clr_cmd_i,
   input wire logic [1:0] fw_req_i,
   output logic fw_grant_o,
   output logic pps_o,
   output logic even_second_pulse_o,
   output logic prog_pulse_o,
   output logic irig_dc_o,
   output logic irig_carrier_o,
   output logic power_led_o,
   output logic lock_led_o,
   output logic holdover_led_o,
   output logic outputs_valid_o,
   output logic alarm_led_o,
   output logic alarm_n_o,
   output logic self_test_alarm_relay_o
);

   // ==========================================
   // State.
   typedef struct packed {
      logic trk_m;
      logic trk_s;
      logic alm_m;
      logic alm_s;
      logic ack;
      logic [31:0] rdat;
      logic [15:0] ms_cnt;
      logic [9:0] ms_idx;
      logic [3:0] bit_ms;
      logic [6:0] bit_idx;
      logic [5:0] sec;
      logic [5:0] min;
      logic [4:0] hour;
      logic [8:0] day;
      logic [16:0] sod;
      gtos_mode_e mode;
      logic manual;
      logic [17:0] warm_s;
      logic [17:0] lock_s;
      logic alarm;
      logic fw_ref;
      logic fw_grant;
      logic pp_en;
      logic pp_per;
      logic pp_armed;
      logic [16:0] pp_time;
      logic [24:0] pp_period;
      logic [24:0] pp_cnt;
      logic pp_act;
      logic pps;
      logic even;
      logic pp;
      logic irig;
      logic car;
   } gtos_state_s;

   gtos_state_s s_r;
   gtos_state_s s_nxt;
   logic req;
   logic wr;
   logic ms_tick;
   logic sec_tick;
   logic fire;
   logic go_hold;
   logic go_rec;
   logic alm_clr;
   logic trk_ok;
   logic [7:0] su;
   logic [7:0] mu;
   logic [7:0] hu;
   logic [11:0] du;
   logic [99:0] fv;
   logic [3:0] bw;

   function automatic logic [7:0] bcd2(input logic [6:0] v);
      bcd2 = {4'(v / 7'd10), 4'(v % 7'd10)};
   endfunction

   // ==========================================
   // Next state.
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.trk_m = tracking_i;
      s_nxt.trk_s = s_r.trk_m;
      s_nxt.alm_m = alarm_cond_i;
      s_nxt.alm_s = s_r.alm_m;
      req = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr = req & wb_we_i & (wb_sel_i == 4'hF);
      s_nxt.ack = req;

      // Bus reads.
      s_nxt.rdat = 32'h0000_0000;
      if (req & ~wb_we_i)
      begin
         unique case (wb_adr_i)
            ADR_CTRL:
            begin
               s_nxt.rdat[C_PP_EN] = s_r.pp_en;
               s_nxt.rdat[C_PP_PER] = s_r.pp_per;
            end
            ADR_STATUS:
            begin
               s_nxt.rdat[S_LOCK] = (s_r.mode == GTOS_LOCKED);
               s_nxt.rdat[S_HOLD] = (s_r.mode == GTOS_HOLD);
               s_nxt.rdat[S_VALID] = (s_r.mode != GTOS_WARMUP);
               s_nxt.rdat[S_SPEC] = (s_r.warm_s == WARM_SEC) & (s_r.lock_s == LOCK_SEC);
               s_nxt.rdat[S_ALARM] = s_r.alarm;
               s_nxt.rdat[S_MANUAL] = s_r.manual;
               s_nxt.rdat[S_FWREF] = s_r.fw_ref;
               s_nxt.rdat[S_TRACK] = s_r.trk_s;
               s_nxt.rdat[S_ARMED] = s_r.pp_armed;
            end
            ADR_TIME:
               s_nxt.rdat = {s_r.day, 2'b00, s_r.hour, 2'b00, s_r.min, 2'b00, s_r.sec};
            ADR_PP_TIME:
               s_nxt.rdat = {15'h0000, s_r.pp_time};
            ADR_PP_PERIOD:
               s_nxt.rdat = {7'h00, s_r.pp_period};
            default:
               s_nxt.rdat = 32'h0000_0000;
         endcase
      end

      // Commands from either serial port or the bus.
      go_hold = (|hold_cmd_i) | (wr & (wb_adr_i == ADR_CTRL) & wb_dat_i[C_HOLD]);
      go_rec = (|recover_cmd_i) | (wr & (wb_adr_i == ADR_CTRL) & wb_dat_i[C_RECOVER]);
      alm_clr = (|alarm_clr_cmd_i) | (wr & (wb_adr_i == ADR_CTRL) & wb_dat_i[C_ALM_CLR]);

      // Firmware upgrade traffic.
      s_nxt.fw_grant = fw_req_i[0];
      if (wr & (wb_adr_i == ADR_CTRL) & wb_dat_i[C_FW_CLR])
      begin
         s_nxt.fw_ref = 1'b0;
      end
      if (fw_req_i[1])
      begin
         s_nxt.fw_ref = 1'b1;
      end

      // Millisecond and second ticks.
      ms_tick = (s_r.ms_cnt == CYC_PER_MS - 16'h0001);
      sec_tick = ms_tick & (s_r.ms_idx == MS_PER_SEC - 10'h001);
      s_nxt.ms_cnt = ms_tick ? 16'h0000 : s_r.ms_cnt + 16'h0001;
      if (ms_tick)
      begin
         s_nxt.ms_idx = sec_tick ? 10'h000 : s_r.ms_idx + 10'h001;
         if (s_r.bit_ms == BIT_MS - 4'h1)
         begin
            s_nxt.bit_ms = 4'h0;
            s_nxt.bit_idx = sec_tick ? 7'h00 : s_r.bit_idx + 7'h01;
         end
         else
         begin
            s_nxt.bit_ms = s_r.bit_ms + 4'h1;
         end
      end

      // Shared time of day; runs in every lock state.
      if (sec_tick)
      begin
         s_nxt.sod = (s_r.sod == SEC_PER_DAY - 17'h00001) ? 17'h00000 : s_r.sod + 17'h00001;
         s_nxt.sec = s_r.sec + 6'h01;
         if (s_r.sec == 6'h3B)
         begin
            s_nxt.sec = 6'h00;
            s_nxt.min = s_r.min + 6'h01;
            if (s_r.min == 6'h3B)
            begin
               s_nxt.min = 6'h00;
               s_nxt.hour = s_r.hour + 5'h01;
               if (s_r.hour == 5'h17)
               begin
                  s_nxt.hour = 5'h00;
                  s_nxt.day = (s_r.day == DAYS_MAX) ? 9'h001 : s_r.day + 9'h001;
               end
            end
         end
      end
      if (wr & (wb_adr_i == ADR_TIME))
      begin
         s_nxt.sec = wb_dat_i[5:0];
         s_nxt.min = wb_dat_i[13:8];
         s_nxt.hour = wb_dat_i[20:16];
         s_nxt.day = wb_dat_i[31:23];
         s_nxt.sod = 17'(wb_dat_i[20:16] * 17'd3600) + 17'(wb_dat_i[13:8] * 17'd60)
            + 17'(wb_dat_i[5:0]);
      end

      // Programmable pulse.
      if (wr & (wb_adr_i == ADR_CTRL))
      begin
         s_nxt.pp_en = wb_dat_i[C_PP_EN];
         s_nxt.pp_per = wb_dat_i[C_PP_PER];
         s_nxt.pp_cnt = 25'h0000000;
      end
      if (wr & (wb_adr_i == ADR_PP_TIME))
      begin
         s_nxt.pp_time = wb_dat_i[16:0];
         s_nxt.pp_armed = 1'b1;
      end
      if (wr & (wb_adr_i == ADR_PP_PERIOD))
      begin
         s_nxt.pp_period = (wb_dat_i[24:0] > PP_PERIOD_MAX) ? PP_PERIOD_MAX : wb_dat_i[24:0];
      end
      fire = 1'b0;
      if (sec_tick & s_r.pp_en)
      begin
         if (s_r.pp_per)
         begin
            fire = (s_r.pp_cnt + 25'h0000001 >= s_r.pp_period);
            s_nxt.pp_cnt = fire ? 25'h0000000 : s_r.pp_cnt + 25'h0000001;
         end
         else if (s_r.pp_armed & (s_nxt.sod == s_r.pp_time))
         begin
            fire = 1'b1;
            // A target written in the firing cycle keeps the one-shot armed.
            s_nxt.pp_armed = wr & (wb_adr_i == ADR_PP_TIME);
         end
      end
      if (sec_tick)
      begin
         s_nxt.pp_act = fire;
      end

      // Manual holdover and reference state.
      if (go_rec)
      begin
         s_nxt.manual = 1'b0;
      end
      if (go_hold)
      begin
         s_nxt.manual = 1'b1;
      end
      trk_ok = s_r.trk_s & ~s_r.manual;
      unique case (s_r.mode)
         GTOS_WARMUP:
            s_nxt.mode = trk_ok ? GTOS_LOCKED : GTOS_WARMUP;
         GTOS_LOCKED:
            s_nxt.mode = trk_ok ? GTOS_LOCKED : GTOS_HOLD;
         GTOS_HOLD:
            s_nxt.mode = trk_ok ? GTOS_LOCKED : GTOS_HOLD;
         default:
            s_nxt.mode = GTOS_WARMUP;
      endcase
      if (sec_tick & (s_r.warm_s != WARM_SEC))
      begin
         s_nxt.warm_s = s_r.warm_s + 18'h00001;
      end
      if (sec_tick & (s_r.mode == GTOS_LOCKED) & (s_r.lock_s != LOCK_SEC))
      begin
         s_nxt.lock_s = s_r.lock_s + 18'h00001;
      end

      // Latched alarm; a new condition wins over a clear.
      s_nxt.alarm = s_r.alm_s | (s_r.alarm & ~alm_clr);

      // Time-code frame built from the shared counters.
      su = bcd2({1'b0, s_nxt.sec});
      mu = bcd2({1'b0, s_nxt.min});
      hu = bcd2({2'b00, s_nxt.hour});
      du = {4'(s_nxt.day / 9'd100), 4'((s_nxt.day / 9'd10) % 9'd10), 4'(s_nxt.day % 9'd10)};
      fv = '0;
      fv[4:1] = su[3:0];
      fv[8:6] = su[6:4];
      fv[13:10] = mu[3:0];
      fv[17:15] = mu[6:4];
      fv[23:20] = hu[3:0];
      fv[26:25] = hu[5:4];
      fv[33:30] = du[3:0];
      fv[38:35] = du[7:4];
      fv[41:40] = du[9:8];
      fv[88:80] = s_nxt.sod[8:0];
      fv[97:90] = s_nxt.sod[16:9];
      if ((s_nxt.bit_idx == 7'h00) | ((s_nxt.bit_idx % 7'd10) == 7'h09))
      begin
         bw = MARK_MS;
      end
      else
      begin
         bw = fv[s_nxt.bit_idx] ? ONE_MS : ZERO_MS;
      end

      // Second-aligned outputs; pulses from the millisecond index, code from the bit counters.
      s_nxt.pps = (s_nxt.ms_idx < PULSE_MS);
      s_nxt.even = (s_nxt.ms_idx < PULSE_MS) & ~s_nxt.sec[0];
      s_nxt.pp = (s_nxt.ms_idx < PULSE_MS) & s_nxt.pp_act;
      s_nxt.irig = (s_nxt.bit_idx < FRAME_BITS) & (s_nxt.bit_ms < bw);
      // The first carrier half-period after reset is one clock short.
      s_nxt.car = (s_nxt.ms_cnt < (CYC_PER_MS >> 1));
   end

   // ==========================================
   // Registers.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
         s_r.day <= 9'h001;
         s_r.mode <= GTOS_WARMUP;
         s_r.pp_period <= 25'h0000001;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ==========================================
   // Outputs.
   assign wb_dat_o = s_r.rdat;
   assign wb_ack_o = s_r.ack;
   assign fw_grant_o = s_r.fw_grant;
   assign pps_o = s_r.pps;
   assign even_second_pulse_o = s_r.even;
   assign prog_pulse_o = s_r.pp;
   assign irig_dc_o = s_r.irig;
   assign irig_carrier_o = s_r.car;
   assign power_led_o = 1'b1;
   assign lock_led_o = (s_r.mode == GTOS_LOCKED);
   assign holdover_led_o = (s_r.mode == GTOS_HOLD);
   assign outputs_valid_o = (s_r.mode != GTOS_WARMUP);
   assign alarm_led_o = s_r.alarm;
   assign alarm_n_o = ~s_r.alarm;
   assign self_test_alarm_relay_o = s_r.alarm;

endmodule

/* common/gtos_pkg.sv */
package gtos_pkg;
   // ==========================================
   // Clock and timing.
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
   localparam logic [9:0] MS_PER_SEC = 10'h3E8;
   localparam logic [9:0] PULSE_MS = 10'h00A;
   localparam logic [16:0] SEC_PER_DAY = 17'h15180;
   localparam logic [8:0] DAYS_MAX = 9'h16E;
   localparam logic [17:0] WARM_SEC = 18'h15180;
   localparam logic [17:0] LOCK_SEC = 18'h2A300;
   localparam logic [24:0] PP_PERIOD_MAX = 25'h1E28500;
   // ==========================================
   // Time-code frame.
   localparam logic [3:0] BIT_MS = 4'hA;
   localparam logic [6:0] FRAME_BITS = 7'h64;
   localparam logic [3:0] ZERO_MS = 4'h2;
   localparam logic [3:0] ONE_MS = 4'h5;
   localparam logic [3:0] MARK_MS = 4'h8;
   // ==========================================
   // Register map, byte addresses.
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_TIME = 8'h08;
   localparam logic [7:0] ADR_PP_TIME = 8'h0C;
   localparam logic [7:0] ADR_PP_PERIOD = 8'h10;
   // CTRL bits; the first four are write-one pulses.
   localparam int C_HOLD = 0;
   localparam int C_RECOVER = 1;
   localparam int C_ALM_CLR = 2;
   localparam int C_FW_CLR = 3;
   localparam int C_PP_EN = 4;
   localparam int C_PP_PER = 5;
   // STATUS bits.
   localparam int S_LOCK = 0;
   localparam int S_HOLD = 1;
   localparam int S_VALID = 2;
   localparam int S_SPEC = 3;
   localparam int S_ALARM = 4;
   localparam int S_MANUAL = 5;
   localparam int S_FWREF = 6;
   localparam int S_TRACK = 7;
   localparam int S_ARMED = 8;
   // ==========================================
   // Reference state.
   typedef enum logic [1:0] {
      GTOS_WARMUP = 2'b00,
      GTOS_LOCKED = 2'b01,
      GTOS_HOLD = 2'b10
   } gtos_mode_e;
endpackage

/* tb/gtos_far_model.sv */
`timescale 1ns/1ps
// ==========
// Host on two command ports, timing gear levels.
module gtos_far_model
   import gtos_pkg::*;
(
   input wire logic go_i,
   input wire logic [1:0] op_i,
   input wire logic port_i,
   input wire logic trk_i,
   input wire logic flt_i,
   output logic tracking_o,
   output logic alarm_cond_o,
   output logic [1:0] hold_o,
   output logic [1:0] recover_o,
   output logic [1:0] clr_o,
   output logic [1:0] fw_o
);
   logic [1:0] sel;
   assign sel = go_i ? (port_i ? 2'h2 : 2'h1) : 2'h0;
   assign hold_o = (op_i == 2'h0) ? sel : 2'h0;
   assign recover_o = (op_i == 2'h1) ? sel : 2'h0;
   assign clr_o = (op_i == 2'h2) ? sel : 2'h0;
   assign fw_o = (op_i == 2'h3) ? sel : 2'h0;
   assign tracking_o = trk_i;
   assign alarm_cond_o = flt_i;
endmodule

/* tb/gtos_core_asserts.sv */
`timescale 1ns/1ps
module gtos_core_asserts
   import gtos_pkg::*;
#(
   parameter logic [15:0] CYC_PER_MS = 16'h0014
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [1:0] alarm_clr_cmd_i,
   input wire logic [1:0] fw_req_i,
   input wire logic fw_grant_o,
   input wire logic pps_o,
   input wire logic even_second_pulse_o,
   input wire logic irig_dc_o,
   input wire logic irig_carrier_o,
   input wire logic lock_led_o,
   input wire logic holdover_led_o,
   input wire logic outputs_valid_o,
   input wire logic alarm_led_o,
   input wire logic alarm_n_o,
   input wire logic self_test_alarm_relay_o
);
   logic [15:0] hcnt_r;
   logic hfull_r;
   always_ff @(posedge clk_i)
   begin
      hcnt_r <= irig_carrier_o ? hcnt_r + 16'h0001 : 16'h0000;
      hfull_r <= ~rst_i & (hfull_r | (~irig_carrier_o & (hcnt_r != 16'h0000)));
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   AST_WB_ACK: assert property (s_req |=> s_ans) else $error("ack");
   AST_ALARM_PINS: assert property (alarm_n_o == !alarm_led_o
      && self_test_alarm_relay_o == alarm_led_o) else $error("alarm pins");
   AST_ALARM_LATCH: assert property (alarm_led_o && !wb_stb_i && !$past(wb_stb_i)
      && alarm_clr_cmd_i == 2'h0 |=> alarm_led_o) else $error("alarm latch");
   AST_EVEN_IN_PPS: assert property (even_second_pulse_o |-> pps_o) else $error("even");
   AST_FRAME_ALIGN: assert property ($rose(pps_o) |-> irig_dc_o) else $error("frame");
   AST_CARRIER_HALF: assert property ($fell(irig_carrier_o) && hfull_r
      |-> hcnt_r == CYC_PER_MS / 2) else $error("carrier");
   AST_CARRIER_FIRST: assert property ($fell(irig_carrier_o) && !hfull_r
      |-> hcnt_r == CYC_PER_MS / 2 - 16'h0001) else $error("carrier first");
   AST_LOCK_EXCL: assert property (lock_led_o |-> !holdover_led_o
      && outputs_valid_o) else $error("lock");
   AST_FW_REAR: assert property (fw_req_i[0] |=> fw_grant_o) else $error("fw rear");
   AST_FW_FRONT: assert property (fw_grant_o |-> $past(fw_req_i[0])) else $error("fw");
endmodule
bind gtos_core gtos_core_asserts #(.CYC_PER_MS(CYC_PER_MS)) i_gtos_core_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .alarm_clr_cmd_i(alarm_clr_cmd_i), .fw_req_i(fw_req_i),
   .fw_grant_o(fw_grant_o), .pps_o(pps_o), .even_second_pulse_o(even_second_pulse_o),
   .irig_dc_o(irig_dc_o), .irig_carrier_o(irig_carrier_o), .lock_led_o(lock_led_o),
   .holdover_led_o(holdover_led_o), .outputs_valid_o(outputs_valid_o),
   .alarm_led_o(alarm_led_o), .alarm_n_o(alarm_n_o),
   .self_test_alarm_relay_o(self_test_alarm_relay_o));

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench
   import gtos_pkg::*;
;
   localparam int MSC = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, port = 1'b0, trk = 1'b0, flt = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000, rdat, rd;
   logic [1:0] op = 2'h0;
   logic [1:0] hc, rc, cc, fc;
   logic ack, gnt, pps, evn, prg, irig, car, pwr, lck, hld, vld, alm, alm_n, rly, trs, fls;
   int n_errors = 0, total_checks = 0, cyc_cnt = 0, c, ncar = 0, n_gnt = 0;
   logic [99:0] bv;
   always #12.5 clk_i = ~clk_i;
   gtos_core #(.CYC_PER_MS(16'h0014)) i_gtos_core (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tracking_i(trs),
      .alarm_cond_i(fls), .hold_cmd_i(hc), .recover_cmd_i(rc), .alarm_clr_cmd_i(cc),
      .fw_req_i(fc), .fw_grant_o(gnt), .pps_o(pps), .even_second_pulse_o(evn),
      .prog_pulse_o(prg), .irig_dc_o(irig), .irig_carrier_o(car), .power_led_o(pwr),
      .lock_led_o(lck), .holdover_led_o(hld), .outputs_valid_o(vld), .alarm_led_o(alm),
      .alarm_n_o(alm_n), .self_test_alarm_relay_o(rly));
   gtos_far_model i_gtos_far_model (.go_i(go), .op_i(op), .port_i(port), .trk_i(trk),
      .flt_i(flt), .tracking_o(trs), .alarm_cond_o(fls), .hold_o(hc), .recover_o(rc),
      .clr_o(cc), .fw_o(fc));
   // ==========
   // Bus, host and compare tasks.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic host(input logic [1:0] o, input logic p);
      @(posedge clk_i);
      go <= 1'b1;
      op <= o;
      port <= p;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (6) @(negedge clk_i);
   endtask
   task automatic level(input logic t, input logic f);
      @(posedge clk_i);
      trk <= t;
      flt <= f;
      repeat (8) @(negedge clk_i);
   endtask
   task automatic wpps;
      @(negedge clk_i);
      while (pps === 1'b1) @(negedge clk_i);
      while (pps !== 1'b1) @(negedge clk_i);
   endtask
   function automatic int gf(input int s, input int n);
      gf = 0;
      for (int k = 0; k < n; k++) gf += int'(bv[s + k]) << k;
   endfunction
   task give_verdict;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc_cnt++;
      if (cyc_cnt == 70000)
      begin
         n_errors++;
         $display("BAD t=%0t timeout", $time);
         give_verdict;
      end
   end
   always @(negedge clk_i)
   begin
      if (gnt === 1'b1) n_gnt++;
   end
   // ==========
   // Main sequence.
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({pwr, alm_n, rly, lck, vld}, 5'h18);
      wb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0);
      level(1'b1, 1'b0);
      chk({lck, hld, vld}, 3'h5);
      wb(1'b1, ADR_CTRL, 32'h1);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk({lck, hld, rd[S_MANUAL]}, 3'h3);
      host(2'h1, 1'b1);
      chk({lck, hld}, 2'h2);
      level(1'b1, 1'b1);
      level(1'b1, 1'b0);
      chk({alm, alm_n, rly}, 3'h5);
      host(2'h2, 1'b0);
      chk({alm, alm_n, rly}, 3'h2);
      host(2'h3, 1'b1);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd[S_FWREF], 1'b1);
      chk(n_gnt, 32'h00000000);
      host(2'h3, 1'b0);
      chk(n_gnt, 32'h00000001);
      wb(1'b1, ADR_PP_PERIOD, 32'hFFFFFFFF);
      wb(1'b0, ADR_PP_PERIOD, 32'h0);
      chk(rd, {7'h00, PP_PERIOD_MAX});
      wb(1'b1, ADR_PP_PERIOD, 32'h1);
      wb(1'b1, ADR_TIME, {9'h0AD, 2'h0, 5'h15, 2'h0, 6'h12, 2'h0, 6'h29});
      wb(1'b1, ADR_CTRL, 32'h30);
      wpps;
      chk({evn, prg}, 2'h3);
      for (int i = 0; i < 100; i++)
      begin
         c = 0;
         repeat (10 * MSC)
         begin
            c += int'(irig);
            ncar += int'(car);
            @(negedge clk_i);
         end
         bv[i] = (c == ONE_MS * MSC);
         if (i % 10 == 9 || i == 0) chk(c, MARK_MS * MSC);
      end
      chk(ncar, FRAME_BITS * BIT_MS * MSC / 2);
      chk(((gf(20, 4) + 10 * gf(25, 2)) * 100 + gf(10, 4) + 10 * gf(15, 3)) * 100
         + gf(1, 4) + 10 * gf(6, 3), 32'h00033B82);
      chk(gf(30, 4) + 10 * gf(35, 4) + 100 * gf(40, 2), 32'h000000AD);
      chk(gf(80, 9) + 512 * gf(90, 8), 32'h00012BB2);
      chk({pps, evn, prg}, 3'h5);
      wb(1'b1, ADR_CTRL, 32'h10);
      wb(1'b1, ADR_PP_TIME, 32'h00012BB4);
      level(1'b0, 1'b0);
      chk({lck, hld, vld}, 3'h3);
      wpps;
      chk({pps, evn, prg}, 3'h7);
      level(1'b1, 1'b0);
      chk({lck, hld}, 2'h2);
      give_verdict;
   end
endmodule
